/* common/l2ctl_if.sv */
// Signals shared by the top and its hit sampler and tag sequencer
`timescale 1ns/1ps
interface l2ctl_if;
  l2ctl_pkg::l2ctl_cfg_t cfg;
  logic ts;
  logic aphase_end;
  logic match_in;
  logic hit_valid;
  logic hit;
  logic claim;
  logic tag_rd;
  logic tag_wr;
  logic wr_valid;
  logic wr_dirty;
  logic toe_n;
  logic twe_n;
  logic tv_o;
  logic tv_oe;
  logic dirty_o;
  logic tag_busy;
  modport top (output cfg, ts, aphase_end, match_in, tag_rd, tag_wr,
    wr_valid, wr_dirty, input hit_valid, hit, claim, toe_n, twe_n,
    tv_o, tv_oe, dirty_o, tag_busy);
  modport smp (input cfg, ts, aphase_end, match_in,
    output hit_valid, hit, claim);
  modport tag (input cfg, tag_rd, tag_wr, wr_valid, wr_dirty,
    output toe_n, twe_n, tv_o, tv_oe, dirty_o, tag_busy);
endinterface : l2ctl_if

/* common/l2ctl_pkg.sv */
// Shared constants, types and helpers of the L2 pin controller
package l2ctl_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DLY_W = 3;
  localparam int HCNT_W = 16;
  localparam int WE_N = 3;
  localparam logic [ADDR_W-1:0] CFG_OFS = 8'h00;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] HCNT_OFS = 8'h08;
  // Remaining tag output enable cycles after the first one
  localparam logic [1:0] TOE_EXTRA_SHORT = 2'h1;
  localparam logic [1:0] TOE_EXTRA_LONG = 2'h2;
  localparam logic [3:0] AGE_MAX = 4'hF;
  // Bit 0 upward: hit polarity, delay, tag read length, status polarity,
  // quick evict, keep driving, external controller mode
  typedef struct packed {
    logic ext_mode;
    logic tag_status_keep;
    logic quick_evict_mode;
    logic status_bit_polarity;
    logic tag_read_pulse_len;
    logic [DLY_W-1:0] lookup_delay_count;
    logic lookup_match_polarity;
  } l2ctl_cfg_t;
  localparam int CFG_W = $bits(l2ctl_cfg_t);
  localparam logic [CFG_W-1:0] CFG_RST = 9'h000;
  typedef enum logic [3:0] {
    L2C_IDLE = 4'h1,
    L2C_READ = 4'h2,
    L2C_WRITE = 4'h4,
    L2C_HOLD = 4'h8
  } l2ctl_tag_st_t;
  // Maps a logical level to a pin level; hi set means active high
  function automatic logic apply_pol(input logic v, input logic hi);
    apply_pol = hi ? v : !v;
  endfunction : apply_pol
endpackage : l2ctl_pkg

/* design/l2ctl_hit_sampler.sv */
// Samples the lookup-match input a programmed delay after transfer start
`timescale 1ns/1ps
module l2ctl_hit_sampler (
  input wire logic clk,
  input wire logic resetn,
  l2ctl_if.smp bus
);
  typedef struct packed {
    logic [l2ctl_pkg::DLY_W-1:0] cnt;
    logic armed;
    logic hit_valid;
    logic hit;
    logic claim;
    logic [3:0] age;
  } l2ctl_smp_t;
  l2ctl_smp_t s;
  l2ctl_smp_t next_s;
  logic lvl;

  // External controller always drives match active low
  assign lvl = bus.cfg.ext_mode ? !bus.match_in :
    l2ctl_pkg::apply_pol(bus.match_in,
    bus.cfg.lookup_match_polarity);

  always_comb
  begin
    next_s = s;
    next_s.hit_valid = 1'b0;
    if (s.age != l2ctl_pkg::AGE_MAX)
      next_s.age = s.age + 4'h1;
    if (bus.ts)
    begin
      next_s.age = 4'h1;
      next_s.cnt = bus.cfg.lookup_delay_count;
      next_s.armed = (bus.cfg.lookup_delay_count != '0);
      if (bus.cfg.lookup_delay_count == '0)
      begin
        next_s.hit_valid = 1'b1;
        next_s.hit = lvl;
        next_s.claim = bus.cfg.ext_mode && lvl;
      end
    end
    else if (s.armed)
    begin
      next_s.cnt = s.cnt - 1'b1;
      // Input is only valid until the address phase ends
      if (bus.aphase_end && s.cnt != 1)
        next_s.armed = 1'b0;
      else if (s.cnt == 1)
      begin
        next_s.armed = 1'b0;
        next_s.hit_valid = 1'b1;
        next_s.hit = lvl;
        next_s.claim = bus.cfg.ext_mode && lvl;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign bus.hit_valid = s.hit_valid;
  assign bus.hit = s.hit;
  assign bus.claim = s.claim;

  sample_time_a: assert property (@(posedge clk) disable iff (!resetn)
    s.hit_valid |-> s.age == {1'b0, bus.cfg.lookup_delay_count} + 4'h1)
    else $error("lookup match sampled at wrong delay");
endmodule : l2ctl_hit_sampler

/* design/l2ctl_tag_seq.sv */
// Tag RAM read and write pulse sequencer
`timescale 1ns/1ps
module l2ctl_tag_seq (
  input wire logic clk,
  input wire logic resetn,
  l2ctl_if.tag bus
);
  typedef struct packed {
    l2ctl_pkg::l2ctl_tag_st_t st;
    logic [1:0] cnt;
    logic toe_n;
    logic twe_n;
    logic tv_o;
    logic tv_oe;
    logic dirty_o;
  } l2ctl_tag_t;
  l2ctl_tag_t s;
  l2ctl_tag_t next_s;
  logic pol;
  logic rd_drive;

  assign pol = bus.cfg.status_bit_polarity;
  // Float during tag reads only for quick evict without keep
  assign rd_drive = bus.cfg.tag_status_keep ||
    !bus.cfg.quick_evict_mode;

  always_comb
  begin
    next_s = s;
    case (s.st)
      l2ctl_pkg::L2C_IDLE:
      begin
        next_s.tv_oe = 1'b1;
        if (bus.tag_wr && !bus.cfg.ext_mode)
        begin
          next_s.st = l2ctl_pkg::L2C_WRITE;
          next_s.twe_n = 1'b0;
          next_s.tv_o = l2ctl_pkg::apply_pol(bus.wr_valid, pol);
          next_s.dirty_o = l2ctl_pkg::apply_pol(bus.wr_dirty, pol);
        end
        else if (bus.tag_rd && !bus.cfg.ext_mode)
        begin
          next_s.st = l2ctl_pkg::L2C_READ;
          next_s.toe_n = 1'b0;
          next_s.cnt = bus.cfg.tag_read_pulse_len ?
            l2ctl_pkg::TOE_EXTRA_LONG : l2ctl_pkg::TOE_EXTRA_SHORT;
          next_s.tv_oe = rd_drive;
        end
      end
      l2ctl_pkg::L2C_READ:
      begin
        // The count holds the enable cycles still owed after the first
        if (s.cnt == 2'h0)
        begin
          next_s.st = l2ctl_pkg::L2C_IDLE;
          next_s.toe_n = 1'b1;
          next_s.tv_oe = 1'b1;
        end
        else
          next_s.cnt = s.cnt - 2'h1;
      end
      l2ctl_pkg::L2C_WRITE:
      begin
        next_s.st = l2ctl_pkg::L2C_HOLD;
        next_s.twe_n = 1'b1;
      end
      l2ctl_pkg::L2C_HOLD: next_s.st = l2ctl_pkg::L2C_IDLE;
      default:
      begin
        next_s = '0;
        next_s.st = l2ctl_pkg::L2C_IDLE;
        next_s.toe_n = 1'b1;
        next_s.twe_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s <= '0;
      s.st <= l2ctl_pkg::L2C_IDLE;
      s.toe_n <= 1'b1;
      s.twe_n <= 1'b1;
      s.tv_oe <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign bus.toe_n = s.toe_n;
  assign bus.twe_n = s.twe_n;
  assign bus.tv_o = s.tv_o;
  assign bus.tv_oe = s.tv_oe;
  assign bus.dirty_o = s.dirty_o;
  assign bus.tag_busy = (s.st != l2ctl_pkg::L2C_IDLE);

  sequence twe_pulse_s;
    $fell(s.twe_n) ##1 s.twe_n;
  endsequence
  twe_single_a: assert property (@(posedge clk) disable iff (!resetn)
    $fell(s.twe_n) |-> twe_pulse_s)
    else $error("tag write enable not one cycle");
  toe_long_a: assert property (@(posedge clk) disable iff (!resetn)
    ($fell(s.toe_n) && bus.cfg.tag_read_pulse_len) |->
    !s.toe_n [*3] ##1 s.toe_n)
    else $error("tag output enable not three cycles");
  toe_short_a: assert property (@(posedge clk) disable iff (!resetn)
    ($fell(s.toe_n) && !bus.cfg.tag_read_pulse_len) |->
    !s.toe_n [*2] ##1 s.toe_n)
    else $error("tag output enable not two cycles");
  tv_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    $rose(s.twe_n) |-> ($stable(s.tv_o) && $stable(s.dirty_o) && s.tv_oe)
    ##1 ($stable(s.tv_o) && $stable(s.dirty_o) && s.tv_oe))
    else $error("tag status not held after write");
  tv_float_a: assert property (@(posedge clk) disable iff (!resetn)
    (!s.toe_n && $stable(rd_drive)) |-> s.tv_oe == rd_drive)
    else $error("tag valid drive wrong during read");
endmodule : l2ctl_tag_seq

/* design/l2ctl_top.sv */
// L2 cache SRAM pin control and external controller grants, APB slave
//
// Local design decisions: the APB register port and the placing of the registers.
`timescale 1ns/1ps
module l2ctl_top (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [l2ctl_pkg::ADDR_W-1:0] PADDR,
  input wire logic [l2ctl_pkg::DATA_W-1:0] PWDATA,
  output logic [l2ctl_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic TRANSFER_START,
  input wire logic ADDR_PHASE_ACK,
  input wire logic LOOKUP_MATCH,
  input wire logic RAM_RD_REQ,
  input wire logic RAM_WR_REQ,
  input wire logic TAG_RD_REQ,
  input wire logic TAG_WR_REQ,
  input wire logic TAG_WR_VALID,
  input wire logic TAG_WR_DIRTY,
  input wire logic ADDR_BUS_FREE,
  input wire logic DATA_BUS_IDLE,
  input wire logic EXT_DATA_TOP,
  input wire logic EXT_CACHE_REQUEST_N,
  output logic L2_RAM_OUTPUT_EN_N,
  output logic [l2ctl_pkg::WE_N-1:0] L2_RAM_WRITE_EN_N,
  output logic TAG_RAM_OUTPUT_EN_N,
  output logic TAG_WRITE_EN_N,
  output logic TAG_VALID_BIT_O,
  output logic TAG_VALID_BIT_OE,
  output logic LINE_MODIFIED,
  output logic EXT_CACHE_ADDR_GRANT_N,
  output logic EXT_CACHE_XFER_GRANT_N,
  output logic L2_HIT_VALID,
  output logic L2_HIT,
  output logic EXT_CLAIM
);
  typedef struct packed {
    l2ctl_pkg::l2ctl_cfg_t cfg;
    logic [l2ctl_pkg::DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
    logic doe_n;
    logic [l2ctl_pkg::WE_N-1:0] dwe_n;
    logic agrant_n;
    logic accepted;
    logic xgrant_n;
    logic xdone;
    logic [l2ctl_pkg::HCNT_W-1:0] hcnt;
  } l2ctl_top_t;

  l2ctl_top_t s;
  l2ctl_top_t next_s;
  l2ctl_if lif ();
  logic setup;
  logic wr_take;
  logic ext;
  logic req;

  function automatic logic mapped(
    input logic [l2ctl_pkg::ADDR_W-1:0] a);
    mapped = (a == l2ctl_pkg::CFG_OFS) ||
      (a == l2ctl_pkg::STAT_OFS) || (a == l2ctl_pkg::HCNT_OFS);
  endfunction : mapped

  assign setup = PSEL && !PENABLE;
  assign wr_take = PSEL && PENABLE && s.pready && PWRITE;
  assign ext = s.cfg.ext_mode;
  assign req = !EXT_CACHE_REQUEST_N;

  assign lif.cfg = s.cfg;
  assign lif.ts = TRANSFER_START;
  assign lif.aphase_end = ADDR_PHASE_ACK;
  assign lif.match_in = LOOKUP_MATCH;
  assign lif.tag_rd = TAG_RD_REQ;
  assign lif.tag_wr = TAG_WR_REQ;
  assign lif.wr_valid = TAG_WR_VALID;
  assign lif.wr_dirty = TAG_WR_DIRTY;

  l2ctl_hit_sampler u_smp (
    .clk(CLK),
    .resetn(RESETN),
    .bus(lif.smp)
  );

  l2ctl_tag_seq u_tag (
    .clk(CLK),
    .resetn(RESETN),
    .bus(lif.tag)
  );

  always_comb
  begin
    next_s = s;
    // Zero wait state: answer is prepared in the setup cycle
    next_s.pready = setup;
    next_s.pslverr = 1'b0;
    if (setup)
    begin
      next_s.prdata = '0;
      if (!mapped(PADDR))
        next_s.pslverr = 1'b1;
      else if (PWRITE && PADDR != l2ctl_pkg::CFG_OFS)
        next_s.pslverr = 1'b1;
      else if (!PWRITE)
      begin
        case (PADDR)
          l2ctl_pkg::CFG_OFS:
            next_s.prdata[l2ctl_pkg::CFG_W-1:0] = s.cfg;
          l2ctl_pkg::STAT_OFS:
            next_s.prdata[6:0] = {lif.tag_busy, s.xdone, s.accepted,
              !s.xgrant_n, !s.agrant_n, lif.claim, lif.hit};
          l2ctl_pkg::HCNT_OFS:
            next_s.prdata[l2ctl_pkg::HCNT_W-1:0] = s.hcnt;
          default: next_s.prdata = '0;
        endcase
      end
    end
    if (wr_take && PADDR == l2ctl_pkg::CFG_OFS)
      next_s.cfg = PWDATA[l2ctl_pkg::CFG_W-1:0];

    if (lif.hit_valid && lif.hit)
      next_s.hcnt = s.hcnt + 1'b1;

    // Write wins so the RAMs never drive against our write data
    next_s.doe_n = !(RAM_RD_REQ && !RAM_WR_REQ && !ext);
    next_s.dwe_n = {l2ctl_pkg::WE_N{!(RAM_WR_REQ && !ext)}};

    // Grant pins only act in external controller mode
    if (!ext)
    begin
      next_s.agrant_n = 1'b1;
      next_s.accepted = 1'b0;
    end
    else if (!s.agrant_n && TRANSFER_START)
    begin
      // Grant used: withhold until the request is seen inactive
      next_s.agrant_n = 1'b1;
      next_s.accepted = 1'b1;
    end
    else if (s.accepted)
    begin
      next_s.agrant_n = 1'b1;
      if (!req)
        next_s.accepted = 1'b0;
    end
    else
      next_s.agrant_n = !(req && ADDR_BUS_FREE);

    if (!ext || !EXT_DATA_TOP)
      next_s.xdone = 1'b0;
    if (ext && DATA_BUS_IDLE && EXT_DATA_TOP && s.xgrant_n && !s.xdone)
    begin
      next_s.xgrant_n = 1'b0;
      next_s.xdone = 1'b1;
    end
    else
      next_s.xgrant_n = 1'b1;
  end

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      s <= '0;
      s.cfg <= l2ctl_pkg::CFG_RST;
      s.doe_n <= 1'b1;
      s.dwe_n <= '1;
      s.agrant_n <= 1'b1;
      s.xgrant_n <= 1'b1;
    end
    else
      s <= next_s;
  end

  assign PRDATA = s.prdata;
  assign PREADY = s.pready;
  assign PSLVERR = s.pslverr;
  assign L2_RAM_OUTPUT_EN_N = s.doe_n;
  assign L2_RAM_WRITE_EN_N = s.dwe_n;
  assign TAG_RAM_OUTPUT_EN_N = lif.toe_n;
  assign TAG_WRITE_EN_N = lif.twe_n;
  assign TAG_VALID_BIT_O = lif.tv_o;
  assign TAG_VALID_BIT_OE = lif.tv_oe;
  assign LINE_MODIFIED = lif.dirty_o;
  assign EXT_CACHE_ADDR_GRANT_N = s.agrant_n;
  assign EXT_CACHE_XFER_GRANT_N = s.xgrant_n;
  assign L2_HIT_VALID = lif.hit_valid;
  assign L2_HIT = lif.hit;
  assign EXT_CLAIM = lif.claim;

  sequence xgrant_pulse_s;
    !s.xgrant_n ##1 s.xgrant_n;
  endsequence

  doe_follow_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (RAM_RD_REQ && !RAM_WR_REQ && !ext) |=> !s.doe_n)
    else $error("data RAM output enable missing on read");
  doe_release_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (!RAM_RD_REQ || RAM_WR_REQ) |=> s.doe_n)
    else $error("data RAM output enable left asserted");
  we_same_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (s.dwe_n == '0 || s.dwe_n == '1) &&
    (s.dwe_n[0] == $past(!(RAM_WR_REQ && !ext))))
    else $error("data RAM write enables differ or lag");
  agrant_cause_a: assert property (@(posedge CLK) disable iff (!RESETN)
    $fell(s.agrant_n) |-> $past(req && ADDR_BUS_FREE && ext))
    else $error("address grant without request or free bus");
  agrant_drop_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (!s.agrant_n && !req) |=> s.agrant_n)
    else $error("address grant kept after request dropped");
  pins_int_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !ext [*2] |-> s.agrant_n && s.xgrant_n)
    else $error("grant pin active in internal mode");
  xgrant_cause_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (ext && DATA_BUS_IDLE && EXT_DATA_TOP && s.xgrant_n && !s.xdone)
    |=> !s.xgrant_n)
    else $error("data grant not given on first idle cycle");
  xgrant_pulse_a: assert property (@(posedge CLK) disable iff (!RESETN)
    $fell(s.xgrant_n) |-> xgrant_pulse_s)
    else $error("data grant longer than one cycle");
  apb_ready_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (PSEL && !PENABLE) |=> s.pready ##1 !s.pready)
    else $error("APB ready not one cycle after setup");
  apb_unmapped_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (PSEL && !PENABLE && !mapped(PADDR)) |=> (s.pready && s.pslverr))
    else $error("unmapped access not refused");
  // In external mode the data RAM strobes must stay quiet
  ext_ram_idle_a: assert property (@(posedge CLK) disable iff (!RESETN)
    ext |=> (s.doe_n && (&s.dwe_n)))
    else $error("data RAM strobe active in external mode");
  agrant_int_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !ext |=> s.agrant_n)
    else $error("address grant given in internal mode");
  claim_ext_a: assert property (@(posedge CLK) disable iff (!RESETN)
    $rose(lif.claim) |-> $past(ext))
    else $error("claim flagged outside external mode");
  xgrant_short_a: assert property (@(posedge CLK) disable iff (!RESETN)
    !s.xgrant_n |=> s.xgrant_n)
    else $error("data grant held two cycles");
  hcnt_step_a: assert property (@(posedge CLK) disable iff (!RESETN)
    (lif.hit_valid && lif.hit) |=> s.hcnt == $past(s.hcnt) + 16'h1)
    else $error("hit counter did not advance");
endmodule : l2ctl_top

/* dv/l2ctl_partner.sv */
// Tag lookup responder and external cache controller request model
`timescale 1ns/1ps
module l2ctl_partner (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ts,
  input wire logic aphase_ack,
  input wire logic hit_want,
  input wire logic hit_hi,
  input wire logic [2:0] dly,
  input wire logic req_want,
  input wire logic addr_grant_n,
  output logic match,
  output logic req_n
);
  logic active;
  logic junk;
  logic backoff;
  logic [3:0] cnt;
  always_ff @(posedge clk or negedge resetn)
    if (!resetn)
    begin
      active <= 1'b0;
      cnt <= 4'h0;
      junk <= 1'b0;
      backoff <= 1'b0;
    end
    else
    begin
      junk <= !junk;
      cnt <= ts ? 4'h1 : cnt + {3'h0, cnt != 4'hF};
      active <= ts | (active & !aphase_ack);
      backoff <= ts & !addr_grant_n;
    end
  // Outside the valid window the line toggles so a stale value never passes
  assign match = (ts | (active & (cnt >= {1'b0, dly}))) ?
    (hit_hi ? hit_want : !hit_want) : junk;
  // Pull-up keeps the request idle when nothing is wanted
  assign req_n = !(req_want & !backoff);
endmodule : l2ctl_partner

/* dv/tb_l2_cache_sram_and_ext_ctrl_signals.sv */
// Self-checking bench for the L2 pin controller
`timescale 1ns/1ps
module tb_l2_cache_sram_and_ext_ctrl_signals;
  logic clk, resetn, psel, penable, pwrite, ts, apa, rrd, rwr, trd, twr;
  logic twv, twd, abf, dbi, edt, hit_want, hit_hi, req_want;
  logic pready, pslverr, match, req_n, oe_n, toe_n, twe_n, tv_o, tv_oe;
  logic lmod, ag_n, xg_n, hv, hit, claim;
  logic [2:0] dly;
  logic [2:0] we_n;
  logic [3:0] wv;
  logic [7:0] paddr;
  logic [8:0] c;
  logic [31:0] pwdata, prdata;
  logic [31:0] cyc = 32'h0;
  logic [33:0] n, h;
  logic [33:0] apq[$];
  logic [33:0] hq[$];
  int error_cnt, cmp_count, hits, k;
  assign wv = {twe_n, toe_n, ag_n, xg_n};

  l2ctl_partner far (.clk(clk), .resetn(resetn), .ts(ts), .aphase_ack(apa),
    .hit_want(hit_want), .hit_hi(hit_hi), .dly(dly), .req_want(req_want),
    .addr_grant_n(ag_n), .match(match), .req_n(req_n));

  l2ctl_top dut (.CLK(clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .TRANSFER_START(ts),
    .ADDR_PHASE_ACK(apa), .LOOKUP_MATCH(match), .RAM_RD_REQ(rrd),
    .RAM_WR_REQ(rwr), .TAG_RD_REQ(trd), .TAG_WR_REQ(twr),
    .TAG_WR_VALID(twv), .TAG_WR_DIRTY(twd), .ADDR_BUS_FREE(abf),
    .DATA_BUS_IDLE(dbi), .EXT_DATA_TOP(edt), .EXT_CACHE_REQUEST_N(req_n),
    .L2_RAM_OUTPUT_EN_N(oe_n), .L2_RAM_WRITE_EN_N(we_n),
    .TAG_RAM_OUTPUT_EN_N(toe_n), .TAG_WRITE_EN_N(twe_n),
    .TAG_VALID_BIT_O(tv_o), .TAG_VALID_BIT_OE(tv_oe), .LINE_MODIFIED(lmod),
    .EXT_CACHE_ADDR_GRANT_N(ag_n), .EXT_CACHE_XFER_GRANT_N(xg_n),
    .L2_HIT_VALID(hv), .L2_HIT(hit), .EXT_CLAIM(claim));

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e,
    input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : results

  task automatic guard;
    if (k >= 20)
    begin
      chk("wait bound", 0, 1);
      results();
    end
  endtask : guard

  // Note: bit 33 compare data, bit 32 expected error, low word read data
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic [33:0] note);
    apq.push_back(note);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    guard();
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cfg(input logic [8:0] v);
    apb(1'b1, l2ctl_pkg::CFG_OFS, {23'h0, v}, 34'h0);
  endtask : cfg

  task automatic wt(input int b, input logic v);
    k = 0;
    while (wv[b] !== v && k < 20)
    begin
      @(posedge clk);
      k++;
    end
    guard();
  endtask : wt

  // Results are matched to the oldest note whenever the design shows one
  always @(posedge clk)
  begin
    cyc <= cyc + 32'h1;
    if (pready === 1'b1)
    begin
      n = apq.size() > 0 ? apq.pop_front() : 34'h3_FFFF_FFFF;
      chk("pslverr", n[32], pslverr);
      if (n[33])
        chk("prdata", n[31:0], prdata);
    end
    if (hv === 1'b1)
    begin
      h = hq.size() > 0 ? hq.pop_front() : 34'h0;
      chk("hit cycle", h[31:0], cyc);
      chk("hit value", h[32], h[33] ? claim : hit);
    end
  end

  initial
  begin
    {resetn, psel, penable, pwrite, ts, apa, rrd, rwr, trd, twr} = '0;
    {twv, twd, abf, dbi, edt, hit_want, hit_hi, req_want} = '0;
    {dly, paddr, pwdata} = '0;
    error_cnt = 0;
    cmp_count = 0;
    hits = 0;
    void'($urandom(2285));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    chk("reset pins", 32'hFF8,
      {oe_n, we_n, toe_n, twe_n, ag_n, xg_n, tv_oe, tv_o, lmod, hv});
    apb(1'b0, l2ctl_pkg::CFG_OFS, 0, 34'h2_0000_0000);
    c = 9'($urandom) & 9'h0FF;
    cfg(c);
    apb(1'b0, l2ctl_pkg::CFG_OFS, 0, {2'b10, 23'h0, c});
    apb(1'b0, 8'h0C, 0, 34'h1_0000_0000);
    apb(1'b1, l2ctl_pkg::STAT_OFS, '1, 34'h1_0000_0000);
    apb(1'b1, l2ctl_pkg::HCNT_OFS, '1, 34'h1_0000_0000);
    for (int d = 0; d < 8; d++)
    begin
      c = {5'h0, 3'(d), 1'($urandom)};
      hit_want <= 1'($urandom);
      hit_hi <= c[0];
      dly <= 3'(d);
      cfg(c);
      @(posedge clk);
      ts <= 1'b1;
      hq.push_back({1'b0, hit_want, cyc + 32'(d) + 32'h2});
      hits = hits + int'(hit_want);
      @(posedge clk);
      ts <= 1'b0;
      repeat (d + 1) @(posedge clk);
      apa <= 1'b1;
      @(posedge clk);
      apa <= 1'b0;
    end
    apb(1'b0, l2ctl_pkg::HCNT_OFS, 0, {2'b10, 32'(hits)});
    // Address phase ends before a three cycle delay runs out
    cfg(9'h006);
    @(posedge clk);
    ts <= 1'b1;
    @(posedge clk);
    ts <= 1'b0;
    apa <= 1'b1;
    @(posedge clk);
    apa <= 1'b0;
    repeat (6) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      cfg({1'b0, 1'(i >> 2), 1'(i >> 1), 1'b0, 1'(i), 4'h0});
      @(posedge clk);
      trd <= 1'b1;
      @(posedge clk);
      trd <= 1'b0;
      wt(2, 1'b0);
      chk("tag valid drive", !(i[1] & !i[2]), tv_oe);
      k = 0;
      while (toe_n === 1'b0 && k < 9)
      begin
        k++;
        @(posedge clk);
      end
      chk("tag read length", 2 + i[0], k);
    end
    for (int i = 0; i < 8; i++)
    begin
      cfg({3'h0, 1'(i), 5'h00});
      @(posedge clk);
      twr <= 1'b1;
      twv <= i[1];
      twd <= i[2];
      @(posedge clk);
      twr <= 1'b0;
      wt(3, 1'b0);
      c = {6'h0, 1'b1, i[0] ~^ i[1], i[0] ~^ i[2]};
      chk("tag status", c, {tv_oe, tv_o, lmod});
      @(posedge clk);
      chk("tag tail", c, {twe_n, tv_o, lmod});
    end
    rwr <= 1'b1;
    rrd <= 1'b1;
    repeat (2) @(posedge clk);
    chk("ram write", 4'h8, {oe_n, we_n});
    rwr <= 1'b0;
    repeat (2) @(posedge clk);
    chk("ram read", 4'h7, {oe_n, we_n});
    rrd <= 1'b0;
    repeat (2) @(posedge clk);
    chk("ram idle", 4'hF, {oe_n, we_n});
    cfg(9'h100);
    rwr <= 1'b1;
    hit_hi <= 1'b0;
    hit_want <= 1'b1;
    dly <= 3'h0;
    @(posedge clk);
    req_want <= 1'b1;
    abf <= 1'b1;
    repeat (2) @(posedge clk);
    chk("addr grant", 0, ag_n);
    chk("ext ram idle", 4'hF, {oe_n, we_n});
    ts <= 1'b1;
    hq.push_back({1'b1, 1'b1, cyc + 32'h2});
    @(posedge clk);
    ts <= 1'b0;
    wt(1, 1'b1);
    wt(1, 1'b0);
    apa <= 1'b1;
    @(posedge clk);
    apa <= 1'b0;
    abf <= 1'b0;
    wt(1, 1'b1);
    dbi <= 1'b1;
    edt <= 1'b1;
    repeat (2) @(posedge clk);
    chk("data grant", 0, xg_n);
    @(posedge clk);
    chk("data grant end", 1, xg_n);
    // Status: hit and claim set, grant used and released, data grant done
    apb(1'b0, l2ctl_pkg::STAT_OFS, 0, {2'b10, 32'h23});
    results();
  end
endmodule : tb_l2_cache_sram_and_ext_ctrl_signals
